/* File: logic/cfhp_pkg.sv */
/*
 * constants, types and decode helpers for the cpu-style parallel host port.
 * assumes one instance per channel, all pins synchronous to the 200 MHz clock.
 */
// Behaviour
// R1 - chip select high: ignore strobes, no access, data bus released.
// R2 - read strobe at address 0 presents next receive byte and pops it.
// R3 - write strobe at address 0 pushes the data lines into transmit pipe.
// R4 - read strobe at address 1 drives status byte, pipes untouched.
// R5 - status bit0 data waiting, bit2 suspended, bit3 configured.
// R6 - processor writes only after status bit1 shows transmit room.
// R7 - processor reads only after status bit0 shows received data.
// R8 - status bits 4 to 7 are meaningless; device returns zero there.
// R9 - write strobe at address 1 requests immediate send of pending data.
// R10 - immediate-send request is registered and held in the usb clock domain.
// R11 - each channel instantiates its own independent copy of this port.
// R12 - port only active when configuration memory selects this mode.
// R13 - data bus driven only while select and read strobe both low.
// R14 - one pipe access per strobe pulse; write byte taken at rising edge.
package cfhp_pkg;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned ST_RX_AVAIL   = 0;
    localparam int unsigned ST_TX_FREE    = 1;
    localparam int unsigned ST_SUSPEND    = 2;
    localparam int unsigned ST_CONFIG     = 3;
    localparam logic [3:0]  ST_UNUSED_VAL = 4'h0;
    localparam logic [7:0]  DATA_RST      = 8'h00;
    localparam logic        STROBE_RST    = 1'b1;
    localparam logic        SEL_PIPE      = 1'b0;
    localparam logic        SEL_STATUS    = 1'b1;

    typedef logic [DATA_W-1:0] cfhp_byte_t;

    // decode of one access target, shared by read and write paths
    function automatic logic cfhp_hit(input logic enable, input logic strobe, input logic sel,
                                      input logic want);
        cfhp_hit = enable & strobe & (sel == want);
    endfunction : cfhp_hit
endpackage : cfhp_pkg

/* File: logic/cfhp_strobe_if.sv */
/*
 * strobe events between the pin edge detector and the port core.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface cfhp_strobe_if;
    import cfhp_pkg::*;
    logic       rd_fall;
    logic       rd_sel;
    logic       wr_rise;
    logic       wr_sel;
    cfhp_byte_t wr_data;

    modport det  (output rd_fall, rd_sel, wr_rise, wr_sel, wr_data);
    modport core (input  rd_fall, rd_sel, wr_rise, wr_sel, wr_data);
endinterface : cfhp_strobe_if

/* File: logic/cfhp_strobe.sv */
/*
 * edge detector for the read and write strobes of the host port.
 * assumes pins are synchronous to clk_i; strobes idle high.
 */
`timescale 1ns/1ps
module cfhp_strobe (
    input  wire logic          clk_i,
    input  wire logic          arst_n_i,
    input  wire logic          cs_n_i,
    input  wire logic          register_select_i,
    input  wire logic          rd_n_i,
    input  wire logic          wr_n_i,
    input  wire cfhp_pkg::cfhp_byte_t data_i,
    cfhp_strobe_if.det         strb
);
    import cfhp_pkg::*;

    logic       rd_q;
    logic       wr_q;
    logic       cs_q;
    logic       sel_q;
    cfhp_byte_t data_q;
    logic       next_rd_q;
    logic       next_wr_q;
    logic       next_cs_q;
    logic       next_sel_q;
    cfhp_byte_t next_data_q;

    always_comb begin
        next_rd_q   = rd_n_i;
        next_wr_q   = wr_n_i;
        next_cs_q   = cs_n_i;
        next_sel_q  = register_select_i;
        next_data_q = data_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_q   <= STROBE_RST;
            wr_q   <= STROBE_RST;
            cs_q   <= STROBE_RST;
            sel_q  <= SEL_PIPE;
            data_q <= DATA_RST;
        end else begin
            rd_q   <= next_rd_q;
            wr_q   <= next_wr_q;
            cs_q   <= next_cs_q;
            sel_q  <= next_sel_q;
            data_q <= next_data_q;
        end
    end

    // read acts on the falling edge so the byte is ready early in the pulse
    assign strb.rd_fall = rd_q & ~rd_n_i & ~cs_n_i; // R1 R14
    assign strb.rd_sel  = register_select_i;
    // write uses the last sample while the strobe was low: hold time is short
    assign strb.wr_rise = ~wr_q & wr_n_i & ~cs_q; // R1 R14
    assign strb.wr_sel  = sel_q;
    assign strb.wr_data = data_q;
endmodule : cfhp_strobe

/* File: logic/cfhp_port.sv */
/*
 * cpu-style parallel host port of one channel: data pipes, status, send-now.
 * assumes the usb engine runs on clk_i and pipe handshakes are single-cycle.
 */
`timescale 1ns/1ps
module cfhp_port (
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 mode_enable_i,
    input  wire logic                 cs_n_i,
    input  wire logic                 register_select_i,
    input  wire logic                 rd_n_i,
    input  wire logic                 wr_n_i,
    input  wire cfhp_pkg::cfhp_byte_t data_i,
    output logic [7:0]                data_o,
    output logic                      data_oe_o,
    input  wire logic                 rx_valid_i,
    input  wire cfhp_pkg::cfhp_byte_t rx_data_i,
    output logic                      rx_pop_o,
    input  wire logic                 tx_space_free_i,
    output logic                      tx_push_o,
    output logic [7:0]                tx_data_o,
    input  wire logic                 usb_active_n_i,
    input  wire logic                 configured_i,
    output logic                      flush_o,
    input  wire logic                 flush_ack_i
);
    import cfhp_pkg::*;

    // one instance per channel; nothing here is shared between channels R11
    cfhp_strobe_if strb ();

    cfhp_strobe u_strobe (
        .clk_i             (clk_i),
        .arst_n_i          (arst_n_i),
        .cs_n_i            (cs_n_i),
        .register_select_i (register_select_i),
        .rd_n_i            (rd_n_i),
        .wr_n_i            (wr_n_i),
        .data_i            (data_i),
        .strb              (strb.det)
    );

    cfhp_byte_t status;
    logic       rd_pipe;
    logic       rd_stat;
    logic       wr_pipe;
    logic       wr_stat;
    cfhp_byte_t next_data;
    logic       next_oe;
    logic       next_pop;
    logic       next_push;
    cfhp_byte_t next_tx_data;
    logic       next_flush;

    always_comb begin
        status              = '0;
        status[ST_RX_AVAIL] = rx_valid_i; // R5
        status[ST_TX_FREE]  = tx_space_free_i;
        status[ST_SUSPEND]  = usb_active_n_i; // R5
        status[ST_CONFIG]   = configured_i; // R5
        status[7:4]         = ST_UNUSED_VAL; // R8
    end

    always_comb begin
        rd_pipe      = cfhp_hit(mode_enable_i, strb.rd_fall, strb.rd_sel, SEL_PIPE); // R12
        rd_stat      = cfhp_hit(mode_enable_i, strb.rd_fall, strb.rd_sel, SEL_STATUS); // R12
        wr_pipe      = cfhp_hit(mode_enable_i, strb.wr_rise, strb.wr_sel, SEL_PIPE); // R12
        wr_stat      = cfhp_hit(mode_enable_i, strb.wr_rise, strb.wr_sel, SEL_STATUS); // R12
        next_data    = data_o;
        if (rd_pipe) begin
            next_data = rx_data_i; // R2
        end else if (rd_stat) begin
            next_data = status; // R4
        end
        next_pop     = rd_pipe; // R2
        next_oe      = mode_enable_i & ~cs_n_i & ~rd_n_i; // R13 R1
        next_push    = wr_pipe; // R3
        next_tx_data = wr_pipe ? strb.wr_data : tx_data_o; // R3 R14
        // request stays up until the usb engine takes it; a new set beats the ack
        next_flush   = wr_stat | (flush_o & ~flush_ack_i); // R9 R10
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_o    <= DATA_RST;
            data_oe_o <= 1'b0;
            rx_pop_o  <= 1'b0;
            tx_push_o <= 1'b0;
            tx_data_o <= DATA_RST;
            flush_o   <= 1'b0;
        end else begin
            data_o    <= next_data;
            data_oe_o <= next_oe;
            rx_pop_o  <= next_pop;
            tx_push_o <= next_push;
            tx_data_o <= next_tx_data;
            flush_o   <= next_flush;
        end
    end

    property p_pop_cause;
        @(posedge clk_i) disable iff (!arst_n_i)
        rx_pop_o |-> $past(strb.rd_fall) && ($past(strb.rd_sel) == SEL_PIPE) && $past(mode_enable_i);
    endproperty
    a_pop_cause: assert property (p_pop_cause) else $error("receive pop without pipe read strobe"); // R2

    property p_pop_once;
        @(posedge clk_i) disable iff (!arst_n_i)
        rx_pop_o |=> !rx_pop_o;
    endproperty
    a_pop_once: assert property (p_pop_once) else $error("receive pipe popped twice for one strobe"); // R14

    property p_push_data;
        @(posedge clk_i) disable iff (!arst_n_i)
        tx_push_o |-> $past(strb.wr_rise) && ($past(strb.wr_sel) == SEL_PIPE) && (tx_data_o == $past(data_i, 2));
    endproperty
    a_push_data: assert property (p_push_data) else $error("transmit push wrong cause or byte"); // R3

    property p_status_read;
        @(posedge clk_i) disable iff (!arst_n_i)
        (mode_enable_i && strb.rd_fall && strb.rd_sel == SEL_STATUS) |=>
            (data_o[ST_RX_AVAIL] == $past(rx_valid_i)) && (data_o[ST_SUSPEND] == $past(usb_active_n_i))
            && (data_o[ST_CONFIG] == $past(configured_i)) && !rx_pop_o;
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong or popped pipe"); // R4

    property p_unused_bits;
        @(posedge clk_i) disable iff (!arst_n_i)
        (mode_enable_i && strb.rd_fall && strb.rd_sel == SEL_STATUS) |=>
            (data_o[7:4] == ST_UNUSED_VAL) && (data_o[ST_TX_FREE] == $past(tx_space_free_i));
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("status upper bits not as defined"); // R8

    property p_oe_gate;
        @(posedge clk_i) disable iff (!arst_n_i)
        data_oe_o |-> !$past(cs_n_i) && !$past(rd_n_i) && $past(mode_enable_i);
    endproperty
    a_oe_gate: assert property (p_oe_gate) else $error("data bus driven outside read strobe"); // R13

    property p_cs_idle;
        @(posedge clk_i) disable iff (!arst_n_i)
        cs_n_i ##1 cs_n_i |-> ##1 (!data_oe_o && !rx_pop_o && !tx_push_o);
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("activity while chip select high"); // R1

    property p_flush_set;
        @(posedge clk_i) disable iff (!arst_n_i)
        (mode_enable_i && strb.wr_rise && strb.wr_sel == SEL_STATUS) |=> flush_o && !tx_push_o;
    endproperty
    a_flush_set: assert property (p_flush_set) else $error("send-now write did not raise flush"); // R9

    property p_flush_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        (flush_o && !flush_ack_i) |=> flush_o;
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("flush request dropped before ack"); // R10

    property p_disabled;
        @(posedge clk_i) disable iff (!arst_n_i)
        !mode_enable_i |=> (!data_oe_o && !rx_pop_o && !tx_push_o && ($rose(flush_o) == 1'b0));
    endproperty
    a_disabled: assert property (p_disabled) else $error("port active while mode disabled"); // R12

    property p_pop_data;
        @(posedge clk_i) disable iff (!arst_n_i)
        (mode_enable_i && strb.rd_fall && strb.rd_sel == SEL_PIPE) |=>
            rx_pop_o && data_oe_o && (data_o == $past(rx_data_i));
    endproperty
    a_pop_data: assert property (p_pop_data) else $error("pipe read did not present and pop head byte"); // R2

    property p_push_set;
        @(posedge clk_i) disable iff (!arst_n_i)
        (mode_enable_i && strb.wr_rise && strb.wr_sel == SEL_PIPE) |=>
            tx_push_o && (tx_data_o == $past(strb.wr_data));
    endproperty
    a_push_set: assert property (p_push_set) else $error("pipe write did not push the captured byte"); // R3

    property p_push_once;
        @(posedge clk_i) disable iff (!arst_n_i)
        tx_push_o |=> !tx_push_o;
    endproperty
    a_push_once: assert property (p_push_once) else $error("transmit pipe pushed twice for one strobe"); // R14

    property p_flush_cause;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(flush_o) |-> $past(strb.wr_rise) && ($past(strb.wr_sel) == SEL_STATUS) && $past(mode_enable_i);
    endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("flush raised without send-now write"); // R9

    property p_flush_clear;
        @(posedge clk_i) disable iff (!arst_n_i)
        (flush_o && flush_ack_i && !(mode_enable_i && strb.wr_rise && strb.wr_sel == SEL_STATUS)) |=> !flush_o;
    endproperty
    a_flush_clear: assert property (p_flush_clear) else $error("flush request kept after ack"); // R10

    property p_oe_follow;
        @(posedge clk_i) disable iff (!arst_n_i)
        (mode_enable_i && !cs_n_i && !rd_n_i) |=> data_oe_o;
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("data bus not driven during read strobe"); // R13

    property p_oe_release;
        @(posedge clk_i) disable iff (!arst_n_i)
        (cs_n_i || rd_n_i) |=> !data_oe_o;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("data bus not released after read"); // R13

    property p_cs_no_flush;
        @(posedge clk_i) disable iff (!arst_n_i)
        cs_n_i ##1 cs_n_i |-> ##1 !$rose(flush_o);
    endproperty
    a_cs_no_flush: assert property (p_cs_no_flush) else $error("send-now taken while chip select high"); // R1

    property p_data_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !(mode_enable_i && strb.rd_fall) |=> $stable(data_o);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("bus output byte changed without a read"); // R4

    property p_tx_data_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        !(mode_enable_i && strb.wr_rise && strb.wr_sel == SEL_PIPE) |=> $stable(tx_data_o);
    endproperty
    a_tx_data_hold: assert property (p_tx_data_hold) else $error("transmit byte changed without a push"); // R3
endmodule : cfhp_port

/* File: tb/cfhp_cpu_model.sv */
/*
 * processor on the host port bus: one select, address and strobe sequence per call.
 * assumes calls start at a falling edge of clk_i; released lines read as pulled high.
 */
`timescale 1ns/1ps
module cfhp_cpu_model (
    input  wire logic           clk_i,
    output logic                cs_n_o,
    output logic                register_select_o,
    output logic                rd_n_o,
    output logic                wr_n_o,
    output cfhp_pkg::cfhp_byte_t data_o,
    output logic                data_oe_o
);
    import cfhp_pkg::*;
    initial begin
        cs_n_o            = 1'b1;
        register_select_o = 1'b0;
        rd_n_o            = 1'b1;
        wr_n_o            = 1'b1;
        data_o            = 8'hFF;
        data_oe_o         = 1'b0;
    end
    // select and data settle a cycle before the strobe and stay past its rising edge
    task automatic xfer(input logic cs_n, input logic wr, input logic sel, input cfhp_byte_t d);
        @(negedge clk_i);
        cs_n_o            <= cs_n;
        register_select_o <= sel;
        data_o            <= d;
        data_oe_o         <= wr;
        @(negedge clk_i);
        rd_n_o            <= wr;
        wr_n_o            <= !wr;
        repeat (2) @(negedge clk_i);
        rd_n_o            <= 1'b1;
        wr_n_o            <= 1'b1;
        @(negedge clk_i);
        cs_n_o            <= 1'b1;
        data_oe_o         <= 1'b0;
        data_o            <= ~d;
        @(negedge clk_i);
    endtask : xfer
endmodule : cfhp_cpu_model

/* File: tb/testbench.sv */
/*
 * self-checking bench of the host port: queued expectations, output watcher.
 * assumes the usb side is modelled here as a receive queue and a flush acknowledge.
 */
`timescale 1ns/1ps
module testbench;
    import cfhp_pkg::*;
    logic        clk_i, arst_n_i, mode_enable_i, cs_n_i, register_select_i, rd_n_i, wr_n_i;
    logic        rx_valid_i, tx_space_free_i, usb_active_n_i, configured_i, flush_ack_i;
    logic        data_oe_o, rx_pop_o, tx_push_o, flush_o, cpu_oe, oe_q, fl_q;
    cfhp_byte_t  data_i, rx_data_i, cpu_d, d;
    logic [7:0]  data_o, tx_data_o;
    logic [17:0] exp_q[$];
    cfhp_byte_t  rx_q[$];
    int          n_mismatch, n_checks;
    // the pins are pulled up when nobody drives them
    assign data_i = data_oe_o ? data_o : (cpu_oe ? cpu_d : 8'hFF);
    cfhp_port u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .mode_enable_i(mode_enable_i), .cs_n_i(cs_n_i),
                     .register_select_i(register_select_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .data_i(data_i),
                     .data_o(data_o), .data_oe_o(data_oe_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
                     .rx_pop_o(rx_pop_o), .tx_space_free_i(tx_space_free_i), .tx_push_o(tx_push_o),
                     .tx_data_o(tx_data_o), .usb_active_n_i(usb_active_n_i), .configured_i(configured_i),
                     .flush_o(flush_o), .flush_ack_i(flush_ack_i));
    cfhp_cpu_model u_cpu (.clk_i(clk_i), .cs_n_o(cs_n_i), .register_select_o(register_select_i),
                          .rd_n_o(rd_n_i), .wr_n_o(wr_n_i), .data_o(cpu_d), .data_oe_o(cpu_oe));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic test_done;
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic note(input logic [1:0] k, input logic [7:0] v);
        logic [17:0] e;
        if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("ERROR result expected none seen %h", {k, v});
        end else begin
            e = exp_q.pop_front();
            check("result", {e[17:16], e[7:0]}, {k, v & e[15:8]});
        end
    endtask : note
    task automatic rx_refresh;
        rx_valid_i <= (rx_q.size() != 0);
        rx_data_i  <= (rx_q.size() != 0) ? rx_q[0] : ~rx_data_i;
    endtask : rx_refresh
    // kind 0 bus read, 1 transmit push, 2 send-now raised
    always @(negedge clk_i) begin
        oe_q <= data_oe_o;
        fl_q <= flush_o;
        if (data_oe_o === 1'b1 && oe_q !== 1'b1) note(2'd0, data_o);
        if (tx_push_o === 1'b1) note(2'd1, tx_data_o);
        if (flush_o === 1'b1 && fl_q !== 1'b1) note(2'd2, 8'h00);
    end
    // the receive pipe moves at the falling edge, like every other input
    always @(negedge clk_i) begin
        if (rx_pop_o === 1'b1 && rx_q.size() != 0) void'(rx_q.pop_front());
        rx_refresh();
    end
    task automatic status_rd;
        exp_q.push_back({2'd0, 8'h0F, 4'h0, configured_i, usb_active_n_i, tx_space_free_i, (rx_q.size() != 0)});
        u_cpu.xfer(1'b0, 1'b0, 1'b1, 8'h00);
    endtask : status_rd
    initial begin
        #(5ns * 20000);
        n_mismatch++;
        test_done();
    end
    initial begin
        void'($urandom(54));
        {arst_n_i, mode_enable_i, rx_valid_i, rx_data_i, flush_ack_i, oe_q, fl_q} = 14'h1000;
        {tx_space_free_i, usb_active_n_i, configured_i} = 3'h0;
        repeat (3) @(posedge clk_i);
        check("reset", 10'h000, {data_oe_o, rx_pop_o, tx_push_o, flush_o, 6'h00});
        @(negedge clk_i);
        arst_n_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            {usb_active_n_i, configured_i, tx_space_free_i} = i[2:0];
            status_rd();
        end
        for (int i = 0; i < 3; i++) rx_q.push_back(8'($urandom()));
        rx_refresh();
        status_rd();
        for (int i = 0; i < 3; i++) exp_q.push_back({2'd0, 8'hFF, rx_q[i]});
        repeat (3) u_cpu.xfer(1'b0, 1'b0, 1'b0, 8'h00);
        check("rx_left", 10'h000, 10'(rx_q.size()));
        status_rd();
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom());
            exp_q.push_back({2'd1, 8'hFF, d});
            u_cpu.xfer(1'b0, 1'b1, 1'b0, d);
        end
        exp_q.push_back({2'd2, 16'h0000});
        u_cpu.xfer(1'b0, 1'b1, 1'b1, 8'($urandom()));
        repeat (4) @(negedge clk_i);
        check("flush_held", 10'h001, {9'h000, flush_o});
        flush_ack_i = 1'b1;
        @(negedge clk_i);
        flush_ack_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check("flush_ack", 10'h000, {9'h000, flush_o});
        rx_q.push_back(8'($urandom()));
        for (int m = 0; m < 2; m++) begin
            mode_enable_i = 1'(m);
            for (int a = 0; a < 3; a++) u_cpu.xfer(1'(m), 1'(a != 0), 1'(a == 2), 8'h5A);
        end
        check("rx_kept", 10'h001, 10'(rx_q.size()));
        check("pending", 10'h000, 10'(exp_q.size()));
        test_done();
    end
endmodule : testbench
